// *** shared/dcfpc_pkg.sv ***
`default_nettype none
package dcfpc_pkg;

    // ------------------------------------------------------------
    // pin positions in the synchronised pin vector
    // ------------------------------------------------------------
    localparam int PIN_WCLK   = 0;
    localparam int PIN_RCLK   = 1;
    localparam int PIN_SCLK   = 2;
    localparam int PIN_WEN    = 3;
    localparam int PIN_WCS    = 4;
    localparam int PIN_REN    = 5;
    localparam int PIN_RCS    = 6;
    localparam int PIN_OE     = 7;
    localparam int PIN_MRST   = 8;
    localparam int PIN_PRST   = 9;
    localparam int PIN_FTSI   = 10;
    localparam int PIN_ASYNCW = 11;
    localparam int PIN_ASYNCR = 12;
    localparam int PIN_LOAD   = 13;
    localparam int PIN_SERE   = 14;
    localparam int CTRL_PINS  = 15;

    // ------------------------------------------------------------
    // default sizes
    // ------------------------------------------------------------
    localparam int DEF_DATA_W = 18;
    localparam int DEF_ADDR_W = 11;
    localparam int DEF_OFFSET = 127;

    // ------------------------------------------------------------
    // strap levels and reset values
    // ------------------------------------------------------------
    localparam logic SERIAL_LOAD_SEL = 1'h0;
    localparam logic ASYNC_SEL       = 1'h0;
    localparam logic HALF_RST        = 1'h1;
    localparam logic AEMPTY_RST      = 1'h0;
    localparam logic AFULL_RST       = 1'h1;
    localparam logic RCS_DRIVE_RST   = 1'h1;
    localparam logic PIN_IDLE        = 1'h1;

    typedef enum logic {
        DCFPC_STANDARD,
        DCFPC_FALL_THROUGH
    } dcfpc_mode_t;

endpackage
`default_nettype wire

// *** logic/dcfpc_pin_sync.sv ***
`default_nettype none
module dcfpc_pin_sync
    import dcfpc_pkg::*;
#(
    parameter int WIDTH = 1
)(
    // clock and reset
    input  wire logic             i_core_clk,
    input  wire logic             i_rst,
    // raw pins
    input  wire logic [WIDTH-1:0] i_pin,
    // filtered levels
    output logic      [WIDTH-1:0] o_level
);

    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;
    logic [WIDTH-1:0] level_q;
    wire  [WIDTH-1:0] agree;
    wire  [WIDTH-1:0] level_d;

    // a change counts once stages two and three agree
    assign agree   = ~(s2_q ^ s3_q);
    assign level_d = (agree & s2_q) | (~agree & level_q);
    assign o_level = level_q;

    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            s1_q    <= {WIDTH{PIN_IDLE}};
            s2_q    <= {WIDTH{PIN_IDLE}};
            s3_q    <= {WIDTH{PIN_IDLE}};
            level_q <= {WIDTH{PIN_IDLE}};
        end
        else
        begin
            s1_q    <= i_pin;
            s2_q    <= s1_q;
            s3_q    <= s2_q;
            level_q <= level_d;
        end
    end

endmodule
`default_nettype wire

// *** logic/dcfpc_port_ctrl.sv ***
// How it works
// - mode strap sampled in master reset: low standard, high fall-through only when both async select pins are also high.
// - fall-through: first word reaches outputs on third read edge, no enable needed.
// - after master reset the strap pin is serial offset data, if serial chosen.
// - writes start on write clock edges; stopped clock freezes write-side flags.
// - write edges only drive half-full low.
// - async write: each strobe rising edge stores data; host ties enable low.
// - enable low and not full stores one word per write edge; high writes nothing.
// - standard full flag drops when full, rises two write edges after a read.
// - fall-through input-ready rises when full, drops two write edges after read.
// - write enable ignored while full; no store, no pointer move.
// - reads on read clock edges; stopped clock freezes read-side flags.
// - read edges only drive half-full high.
// - async read: strobe edge reads through output register; host ties selects low.
// - write chip select high disables write data inputs.
// - enable low and not empty loads output register per edge; high holds it.
// - standard empty flag low after last read, high two read edges after write.
// - standard read needs read chip select and read enable both low.
// - fall-through output-ready rises on true read of last word; blocks reads.
// - serial enable and load low shift one bit per serial edge; else hold.
// - output enable controls tristate; in reset chip select has no effect.
// - reset: empty low, full high, output-ready high, input-ready low.
`default_nettype none
module dcfpc_port_ctrl
    import dcfpc_pkg::*;
#(
    parameter int DATA_W     = DEF_DATA_W,
    parameter int ADDR_W     = DEF_ADDR_W,
    parameter int DEF_OFFS   = DEF_OFFSET
)(
    // clock and reset
    input  wire logic              i_core_clk,
    input  wire logic              i_rst,
    // write port pins
    input  wire logic              i_wclk_strobe,
    input  wire logic              i_write_enable_n,
    input  wire logic              i_write_chip_select_n,
    input  wire logic [DATA_W-1:0] i_data_in,
    // read port pins
    input  wire logic              i_rclk_strobe,
    input  wire logic              i_read_enable_n,
    input  wire logic              i_read_chip_select_n,
    input  wire logic              i_output_enable_n,
    // reset and configuration pins
    input  wire logic              i_master_reset_n,
    input  wire logic              i_partial_reset_n,
    input  wire logic              i_fallthrough_serial_in,
    input  wire logic              i_async_write_select_n,
    input  wire logic              i_async_read_select_n,
    input  wire logic              i_offset_load_n,
    input  wire logic              i_serial_enable_n,
    input  wire logic              i_serial_clk,
    // data output bus
    output logic      [DATA_W-1:0] o_data_out,
    output logic                   o_data_oe_n,
    // flags
    output logic                   o_empty_flag_n,
    output logic                   o_output_ready_n,
    output logic                   o_full_flag_n,
    output logic                   o_input_ready_n,
    output logic                   o_half_full_n,
    output logic                   o_almost_empty_n,
    output logic                   o_almost_full_n,
    output logic                   o_fall_through_mode
);

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int PTR_W = ADDR_W + 1;
    localparam int DEPTH = 1 << ADDR_W;
    localparam int PIN_W = CTRL_PINS + DATA_W;
    localparam logic [PTR_W-1:0]    FULL_CNT = PTR_W'(DEPTH);
    localparam logic [PTR_W-1:0]    HALF_CNT = PTR_W'(DEPTH / 2);
    localparam logic [2*ADDR_W-1:0] OFFS_RST = {ADDR_W'(DEF_OFFS), ADDR_W'(DEF_OFFS)};

    // ------------------------------------------------------------
    // pin synchronisation
    // ------------------------------------------------------------
    wire  [PIN_W-1:0] pins_raw;
    wire  [PIN_W-1:0] lvl;

    assign pins_raw = {i_data_in, i_serial_enable_n, i_offset_load_n,
                       i_async_read_select_n, i_async_write_select_n,
                       i_fallthrough_serial_in, i_partial_reset_n, i_master_reset_n,
                       i_output_enable_n, i_read_chip_select_n, i_read_enable_n,
                       i_write_chip_select_n, i_write_enable_n, i_serial_clk,
                       i_rclk_strobe, i_wclk_strobe};

    dcfpc_pin_sync #(
        .WIDTH      (PIN_W)
    ) u_pin_sync (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .i_pin      (pins_raw),
        .o_level    (lvl)
    );

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    dcfpc_mode_t         mode_q;
    logic                async_wr_q;
    logic                async_rd_q;
    logic                serial_sel_q;
    logic [2*ADDR_W-1:0] offs_q;
    logic                wclk_prev_q;
    logic                rclk_prev_q;
    logic                sclk_prev_q;
    logic [PTR_W-1:0]    wptr_q;
    logic [PTR_W-1:0]    rptr_q;
    logic [PTR_W-1:0]    rptr_w1_q;
    logic [PTR_W-1:0]    rptr_w2_q;
    logic [PTR_W-1:0]    wptr_r1_q;
    logic [PTR_W-1:0]    wptr_r2_q;
    logic [DATA_W-1:0]   mem_q [DEPTH];
    logic [DATA_W-1:0]   out_q;
    logic                out_valid_q;
    logic                half_n_q;
    logic                aempty_n_q;
    logic                afull_n_q;
    logic                rcs_drive_q;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    wire               in_mrst   = ~lvl[PIN_MRST];
    wire               in_reset  = in_mrst | ~lvl[PIN_PRST];
    wire               fall_through_mode      = (mode_q == DCFPC_FALL_THROUGH);
    wire               load_off  = lvl[PIN_LOAD];
    wire               wr_edge   = lvl[PIN_WCLK] & ~wclk_prev_q;
    wire               rd_edge   = lvl[PIN_RCLK] & ~rclk_prev_q;
    wire               sclk_edge = lvl[PIN_SCLK] & ~sclk_prev_q;
    wire               wupd      = wr_edge | async_wr_q;
    wire               rupd      = rd_edge | async_rd_q;
    wire [PTR_W-1:0]   wfill     = PTR_W'(wptr_q - rptr_w2_q);
    wire [PTR_W-1:0]   rfill     = PTR_W'(wptr_r2_q - rptr_q);
    wire               full      = (wfill == FULL_CNT);
    wire               avail     = (rfill != '0);
    wire [ADDR_W-1:0]  ae_off    = offs_q[ADDR_W-1:0];
    wire [ADDR_W-1:0]  af_off    = offs_q[2*ADDR_W-1:ADDR_W];
    wire [DATA_W-1:0]  wdata     = lvl[PIN_W-1:CTRL_PINS];

    // store on write edge with enable and select low, not full
    wire wr_fire   = wr_edge & ~lvl[PIN_WEN] & ~lvl[PIN_WCS] & load_off & ~full;
    // a read request needs enable and chip select low
    wire true_read = rd_edge & ~lvl[PIN_REN] & ~lvl[PIN_RCS] & load_off;
    wire std_fire  = true_read & avail;
    // fall-through loads an empty output register without a request
    wire ft_fire   = rd_edge & avail & (~out_valid_q | true_read) & load_off;
    wire rd_fire   = fall_through_mode ? ft_fire : std_fire;
    wire ser_fire  = sclk_edge & ~lvl[PIN_SERE] & ~load_off & serial_sel_q;

    wire [PTR_W-1:0] wfill_nx = wr_fire ? PTR_W'(wfill + 1'b1) : wfill;
    wire [PTR_W-1:0] rfill_nx = rd_fire ? PTR_W'(rfill - 1'b1) : rfill;
    wire             half_set = wupd & (wfill_nx > HALF_CNT);
    wire             half_clr = rupd & (rfill_nx <= HALF_CNT);
    wire [PTR_W-1:0] af_level = PTR_W'(FULL_CNT - PTR_W'(af_off));

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign o_data_out          = out_q;
    assign o_data_oe_n         = lvl[PIN_OE] | (~async_rd_q & ~rcs_drive_q);
    assign o_empty_flag_n      = fall_through_mode | avail;
    assign o_output_ready_n    = ~fall_through_mode | ~out_valid_q;
    assign o_full_flag_n       = fall_through_mode | ~full;
    assign o_input_ready_n     = fall_through_mode & full;
    assign o_half_full_n       = half_n_q;
    assign o_almost_empty_n    = aempty_n_q;
    assign o_almost_full_n     = afull_n_q;
    assign o_fall_through_mode = fall_through_mode;

    // ------------------------------------------------------------
    // configuration captured in master reset
    // ------------------------------------------------------------
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            mode_q       <= DCFPC_STANDARD;
            async_wr_q   <= 1'h0;
            async_rd_q   <= 1'h0;
            serial_sel_q <= 1'h0;
        end
        else if (in_mrst)
        begin
            mode_q       <= (lvl[PIN_FTSI] & lvl[PIN_ASYNCW] & lvl[PIN_ASYNCR])
                            ? DCFPC_FALL_THROUGH : DCFPC_STANDARD;
            async_wr_q   <= (lvl[PIN_ASYNCW] == ASYNC_SEL);
            async_rd_q   <= (lvl[PIN_ASYNCR] == ASYNC_SEL);
            serial_sel_q <= (lvl[PIN_LOAD] == SERIAL_LOAD_SEL);
        end
    end

    // ------------------------------------------------------------
    // serial offset register
    // ------------------------------------------------------------
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst || in_mrst)
            offs_q <= OFFS_RST;
        else if (ser_fire)
            offs_q <= {offs_q[2*ADDR_W-2:0], lvl[PIN_FTSI]};
    end

    // ------------------------------------------------------------
    // edge history
    // ------------------------------------------------------------
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            wclk_prev_q <= PIN_IDLE;
            rclk_prev_q <= PIN_IDLE;
            sclk_prev_q <= PIN_IDLE;
        end
        else
        begin
            wclk_prev_q <= lvl[PIN_WCLK];
            rclk_prev_q <= lvl[PIN_RCLK];
            sclk_prev_q <= lvl[PIN_SCLK];
        end
    end

    // ------------------------------------------------------------
    // write side
    // ------------------------------------------------------------
    always_ff @(posedge i_core_clk)
    begin
        if (wr_fire)
            mem_q[wptr_q[ADDR_W-1:0]] <= wdata;
    end

    always_ff @(posedge i_core_clk)
    begin
        if (i_rst || in_reset)
        begin
            wptr_q    <= '0;
            rptr_w1_q <= '0;
            rptr_w2_q <= '0;
            afull_n_q <= AFULL_RST;
        end
        else
        begin
            if (wr_fire)
                wptr_q <= PTR_W'(wptr_q + 1'b1);
            if (wupd)
            begin
                rptr_w1_q <= rptr_q;
                rptr_w2_q <= rptr_w1_q;
                afull_n_q <= (wfill_nx < af_level);
            end
        end
    end

    // ------------------------------------------------------------
    // read side
    // ------------------------------------------------------------
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst || in_reset)
        begin
            rptr_q      <= '0;
            wptr_r1_q   <= '0;
            wptr_r2_q   <= '0;
            out_q       <= '0;
            out_valid_q <= 1'h0;
            aempty_n_q  <= AEMPTY_RST;
            rcs_drive_q <= RCS_DRIVE_RST;
        end
        else
        begin
            if (rd_fire)
            begin
                rptr_q <= PTR_W'(rptr_q + 1'b1);
                out_q  <= mem_q[rptr_q[ADDR_W-1:0]];
            end
            if (rd_edge)
            begin
                out_valid_q <= ft_fire | (out_valid_q & ~true_read);
                rcs_drive_q <= ~lvl[PIN_RCS];
            end
            if (rupd)
            begin
                wptr_r1_q  <= wptr_q;
                wptr_r2_q  <= wptr_r1_q;
                aempty_n_q <= (rfill_nx > PTR_W'(ae_off));
            end
        end
    end

    // ------------------------------------------------------------
    // half-full flag, set from write side, cleared from read side
    // ------------------------------------------------------------
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst || in_reset)
            half_n_q <= HALF_RST;
        else if (half_set)
            half_n_q <= 1'h0;
        else if (half_clr)
            half_n_q <= 1'h1;
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_rst);

    wr_store_a: assert property (!in_reset && wr_fire |=> wptr_q == $past(wptr_q) + 1'b1)
        else $error("write did not advance the write pointer");
    full_block_a: assert property (!in_reset && wr_edge && full |=> $stable(wptr_q))
        else $error("write taken while full");
    wcs_block_a: assert property (!in_reset && lvl[PIN_WCS] |=> $stable(wptr_q))
        else $error("write taken with chip select high");
    half_wr_a: assert property (!in_reset && wr_edge && !rupd |=> !$rose(half_n_q))
        else $error("write edge raised half-full");
    half_rd_a: assert property (!in_reset && rd_edge && !wupd |=> !$fell(half_n_q))
        else $error("read edge lowered half-full");
    rd_hold_a: assert property (!in_reset && !fall_through_mode && rd_edge && lvl[PIN_REN]
                                |=> $stable(out_q) && $stable(rptr_q))
        else $error("output register changed without a read");
    rcs_gate_a: assert property (!in_reset && !fall_through_mode && rd_edge && lvl[PIN_RCS]
                                 |=> $stable(rptr_q))
        else $error("read taken with chip select high");
    empty_read_a: assert property (!in_reset && !avail |=> $stable(rptr_q))
        else $error("read taken while empty");
    ser_hold_a: assert property (!in_mrst && lvl[PIN_SERE] |=> $stable(offs_q))
        else $error("offsets changed with serial enable high");
    oe_tri_a: assert property (lvl[PIN_OE] |-> o_data_oe_n)
        else $error("data bus driven with output enable high");
    reset_flags_a: assert property (in_reset ##1 in_reset
                                    |-> !o_input_ready_n == 1'b1 && o_output_ready_n
                                        && o_full_flag_n && !o_empty_flag_n == !fall_through_mode)
        else $error("flags wrong during reset");
    mode_hold_a: assert property (!in_mrst ##1 !in_mrst |-> $stable(mode_q))
        else $error("mode changed outside master reset");
    ft_first_a: assert property (!in_reset && fall_through_mode && !out_valid_q && rd_edge && avail
                                 && load_off |=> out_valid_q)
        else $error("first word did not fall through");
    wr_lag_a: assert property (!in_reset && wupd && !in_reset ##1 !in_reset
                               |-> rptr_w2_q == $past(rptr_w1_q))
        else $error("read pointer crossing out of step");

endmodule
`default_nettype wire

// *** tb/dcfpc_host_model.sv ***
`default_nettype none
module dcfpc_host_model
    import dcfpc_pkg::*;
#(
    parameter int DATA_W = DEF_DATA_W
)(
    // clock
    input  wire logic              i_core_clk,
    // write port pins
    output logic                   o_wclk,
    output logic                   o_wen_n,
    output logic      [DATA_W-1:0] o_data,
    // read port pins
    output logic                   o_rclk,
    output logic                   o_ren_n
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // host pin drivers
    // ------------------------------------------------------------
    initial
    begin
        o_wclk  = 1'b0;
        o_wen_n = 1'b1;
        o_data  = '0;
        o_rclk  = 1'b0;
        o_ren_n = 1'b1;
    end

    task automatic wr_pulse(input logic [DATA_W-1:0] d, input logic en_n);
        @(posedge i_core_clk);
        o_data  <= d;
        o_wen_n <= en_n;
        repeat (2) @(posedge i_core_clk);
        o_wclk <= 1'b1;
        repeat (4) @(posedge i_core_clk);
        o_wclk <= 1'b0;
        repeat (4) @(posedge i_core_clk);
        o_data  <= ~d;
        o_wen_n <= 1'b1;
    endtask

    task automatic rd_pulse(input logic en_n);
        @(posedge i_core_clk);
        o_ren_n <= en_n;
        repeat (2) @(posedge i_core_clk);
        o_rclk <= 1'b1;
        repeat (4) @(posedge i_core_clk);
        o_rclk <= 1'b0;
        repeat (4) @(posedge i_core_clk);
        o_ren_n <= 1'b1;
    endtask
endmodule
`default_nettype wire

// *** tb/dcfpc_port_ctrl_bench.sv ***
`default_nettype none
module dcfpc_port_ctrl_bench
    import dcfpc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int DW = DEF_DATA_W;
    localparam int AW = 3;
    localparam int DEPTH = 1 << AW;
    localparam logic [5:0] SH_BITS = 6'h0b;
    logic          clk = 1'b0, rst = 1'b1, sample_req = 1'b0, load_n = 1'b1;
    logic          wcs_n = 1'b0, rcs_n = 1'b0, oe_n = 1'b0, mrst_n = 1'b0, ftsi = 1'b0;
    logic          prst_n = 1'b1, sen_n = 1'b1, sclk = 1'b0;
    logic          wclk, wen_n, rclk, ren_n, oe_drv_n, empty_n, oready_n, full_n;
    logic          iready_n, half_n, aempty_n, afull_n, ft_mode;
    logic [DW-1:0] data_in, data_out, w;
    logic [DW-1:0] exp_q[$];
    logic [DW-1:0] fill_q[$];
    int            err_count = 0, cmp_count = 0, cyc = 0, seed = 44654;

    always #4 clk = ~clk;

    dcfpc_port_ctrl #(.ADDR_W(AW), .DEF_OFFS(2)) u_dut (
        .i_core_clk(clk), .i_rst(rst),
        .i_wclk_strobe(wclk), .i_write_enable_n(wen_n),
        .i_write_chip_select_n(wcs_n), .i_data_in(data_in),
        .i_rclk_strobe(rclk), .i_read_enable_n(ren_n),
        .i_read_chip_select_n(rcs_n), .i_output_enable_n(oe_n),
        .i_master_reset_n(mrst_n), .i_partial_reset_n(prst_n),
        .i_fallthrough_serial_in(ftsi), .i_async_write_select_n(1'b1),
        .i_async_read_select_n(1'b1), .i_offset_load_n(load_n),
        .i_serial_enable_n(sen_n), .i_serial_clk(sclk),
        .o_data_out(data_out), .o_data_oe_n(oe_drv_n),
        .o_empty_flag_n(empty_n), .o_output_ready_n(oready_n),
        .o_full_flag_n(full_n), .o_input_ready_n(iready_n),
        .o_half_full_n(half_n), .o_almost_empty_n(aempty_n),
        .o_almost_full_n(afull_n), .o_fall_through_mode(ft_mode));

    dcfpc_host_model u_host (
        .i_core_clk(clk), .o_wclk(wclk), .o_wen_n(wen_n), .o_data(data_in),
        .o_rclk(rclk), .o_ren_n(ren_n));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp, input string what);
        cmp_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("mismatch at %0t: %s", $time, what);
        end
    endtask

    task automatic final_report();
        $display("comparisons %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic wr(input logic en_n);
        w = DW'($random(seed));
        u_host.wr_pulse(w, en_n);
    endtask

    task automatic rd(input logic [DW-1:0] e);
        exp_q.push_back(e);
        u_host.rd_pulse(1'b0);
        @(posedge clk);
        sample_req <= 1'b1;
        @(posedge clk);
        sample_req <= 1'b0;
    endtask

    task automatic mreset(input logic ft);
        @(posedge clk);
        mrst_n <= 1'b0;
        ftsi   <= ft;
        repeat (10) @(posedge clk);
        mrst_n <= 1'b1;
        repeat (4) @(posedge clk);
        ftsi <= 1'b0;
        repeat (6) @(posedge clk);
    endtask

    task automatic shift(input logic b);
        @(posedge clk);
        ftsi <= b;
        repeat (3) @(posedge clk);
        sclk <= 1'b1;
        repeat (4) @(posedge clk);
        sclk <= 1'b0;
    endtask

    always @(posedge clk)
    begin
        if (sample_req === 1'b1)
            chk(data_out, exp_q.pop_front(), "read word");
    end

    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 40000)
        begin
            err_count++;
            $display("mismatch at %0t: run timed out", $time);
            final_report();
        end
    end

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial
    begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        mreset(1'b0);
        chk(ft_mode, 1'b0, "standard mode");
        chk({empty_n, full_n, half_n, aempty_n, afull_n}, 5'h0d, "reset flags");
        $display("test reset done");
        wr(1'b0);
        fill_q.push_back(w);
        repeat (10) @(posedge clk);
        chk(empty_n, 1'b0, "empty frozen while read clock idle");
        repeat (2) u_host.rd_pulse(1'b1);
        chk(empty_n, 1'b1, "empty released");
        chk(data_out, '0, "output held with enable high");
        rcs_n <= 1'b1;
        u_host.rd_pulse(1'b0);
        chk(data_out, '0, "no read with chip select high");
        rcs_n <= 1'b0;
        rd(fill_q.pop_front());
        chk(empty_n, 1'b0, "empty after last word");
        rd(w);
        oe_n <= 1'b1;
        repeat (5) @(posedge clk);
        chk(oe_drv_n, 1'b1, "bus released");
        oe_n <= 1'b0;
        repeat (5) @(posedge clk);
        chk(oe_drv_n, 1'b0, "bus driven");
        $display("test standard read done");
        wcs_n <= 1'b1;
        wr(1'b0);
        wcs_n <= 1'b0;
        wr(1'b1);
        for (int i = 0; i < DEPTH; i++)
        begin
            wr(1'b0);
            fill_q.push_back(w);
        end
        chk(full_n, 1'b0, "full after depth words");
        chk(half_n, 1'b0, "half full set by writes");
        wr(1'b0);
        repeat (2) u_host.rd_pulse(1'b1);
        rd(fill_q.pop_front());
        repeat (2) wr(1'b1);
        chk(full_n, 1'b1, "full cleared two write edges after read");
        while (fill_q.size() > 0)
            rd(fill_q.pop_front());
        chk(half_n, 1'b1, "half full cleared by reads");
        chk(empty_n, 1'b0, "drained");
        $display("test fill and drain done");
        mreset(1'b1);
        chk(ft_mode, 1'b1, "fall-through mode");
        chk({oready_n, iready_n}, 2'h2, "ready flags at reset");
        wr(1'b0);
        repeat (3) u_host.rd_pulse(1'b1);
        chk(data_out, w, "first word falls through");
        chk(oready_n, 1'b0, "output ready");
        u_host.rd_pulse(1'b0);
        chk(oready_n, 1'b1, "output ready drops after last word");
        wr(1'b0);
        repeat (3) u_host.rd_pulse(1'b1);
        repeat (DEPTH) wr(1'b0);
        chk(iready_n, 1'b1, "input ready blocks when full");
        repeat (2) u_host.rd_pulse(1'b1);
        u_host.rd_pulse(1'b0);
        repeat (2) wr(1'b1);
        chk(iready_n, 1'b0, "input ready back after read");
        $display("test fall-through done");
        load_n <= 1'b0;
        mreset(1'b0);
        sen_n <= 1'b0;
        for (int i = 5; i >= 0; i--)
            shift(SH_BITS[i]);
        sen_n <= 1'b1;
        shift(1'b1);
        load_n <= 1'b1;
        repeat (6) wr(1'b0);
        chk(afull_n, 1'b1, "almost full uses shifted offset");
        prst_n <= 1'b0;
        repeat (10) @(posedge clk);
        prst_n <= 1'b1;
        repeat (8) @(posedge clk);
        chk({half_n, afull_n, empty_n}, 3'h6, "flags after partial reset");
        for (int i = 0; i < 7; i++)
        begin
            wr(1'b0);
            fill_q.push_back(w);
            if (i == 5)
                chk(afull_n, 1'b1, "offsets kept over partial reset");
        end
        chk(afull_n, 1'b0, "almost full at shifted offset");
        repeat (2) u_host.rd_pulse(1'b1);
        repeat (4) rd(fill_q.pop_front());
        chk(aempty_n, 1'b0, "almost empty at shifted offset");
        $display("test serial offsets and partial reset done");
        final_report();
    end
endmodule
`default_nettype wire
